// >>> rtl/arf_pkg.sv
package arf_pkg;

  // ****************************************************************
  // Transaction codes
  // ****************************************************************
  localparam logic [3:0] TC_WR_QUAD = 4'h0;
  localparam logic [3:0] TC_WR_BLOCK = 4'h1;
  localparam logic [3:0] TC_WR_RSP = 4'h2;
  localparam logic [3:0] TC_RD_QUAD = 4'h4;
  localparam logic [3:0] TC_RD_BLOCK = 4'h5;
  localparam logic [3:0] TC_RD_QUAD_RSP = 4'h6;
  localparam logic [3:0] TC_RD_BLOCK_RSP = 4'h7;
  localparam logic [3:0] TC_CONFIRM = 4'h8;
  localparam logic [3:0] TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] TC_STREAM = 4'ha;
  localparam logic [3:0] TC_LOCK_RSP = 4'hb;
  localparam logic [3:0] TC_SELF_ID = 4'he;

  // ****************************************************************
  // Acknowledge and stream status codes
  // ****************************************************************
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_PENDING = 4'h2;
  localparam logic [3:0] ACK_DATA_ERROR = 4'hd;
  localparam logic [3:0] STREAM_OK = 4'h1;
  localparam logic [3:0] STREAM_BAD = 4'hd;

  // ****************************************************************
  // Quadlet field positions
  // ****************************************************************
  localparam int HDR_TRANSACTION_CODE_LSB = 4;
  localparam int HDR_LABEL_LSB = 10;
  localparam int HDR_RETRY_LSB = 8;
  localparam int HDR_UPPER_LSB = 16;
  localparam int HDR_RESPONSE_CODE_LSB = 12;
  localparam int TRL_UNSOL_BIT = 16;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic CTRL_ENABLE_RST = 1'b0;

  // ****************************************************************
  // Formatter states
  // ****************************************************************
  typedef enum logic [2:0] {
    ARF_IDLE = 3'b000,
    ARF_HDR = 3'b001,
    ARF_PAY_COLLECT = 3'b010,
    ARF_PAY_WRITE = 3'b011,
    ARF_TRAILER = 3'b100
  } arf_state_e;

endpackage

// >>> rtl/arf_rx_formatter.sv
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module arf_rx_formatter (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Received packet header from the link receiver
  input wire logic pkt_valid_i,
  output logic pkt_ready_o,
  input wire logic [3:0] pkt_transaction_code_i,
  input wire logic [15:0] pkt_dest_node_ident_i,
  input wire logic [5:0] pkt_transaction_label_i,
  input wire logic [1:0] pkt_retry_code_i,
  input wire logic [3:0] pkt_priority_i,
  input wire logic [15:0] pkt_sender_node_ident_i,
  input wire logic [15:0] pkt_dest_offset_upper_i,
  input wire logic [31:0] pkt_dest_offset_lower_i,
  input wire logic [3:0] pkt_response_code_i,
  input wire logic [31:0] pkt_quad_data_i,
  input wire logic [15:0] pkt_data_length_i,
  input wire logic [15:0] pkt_lock_action_code_i,
  input wire logic [31:0] pkt_stream_hdr_i,
  input wire logic pkt_unsolicited_i,
  input wire logic pkt_data_error_i,
  input wire logic pkt_conf_rsp_i,
  // Payload bytes, first byte of the block first
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  input wire logic [7:0] pay_byte_i,
  input wire logic pay_error_i,
  // Receive FIFO write side
  output logic req_wr_o,
  output logic rsp_wr_o,
  output logic [31:0] fifo_data_o,
  input wire logic fifo_ready_i
);

  // ****************************************************************
  // Layout decoding
  // ****************************************************************
  // Index of the last header quadlet for each layout
  function automatic logic [1:0] hdr_last(input logic [3:0] tc);
    if (tc == arf_pkg::TC_WR_RSP || tc == arf_pkg::TC_RD_QUAD) begin
      hdr_last = 2'd2;
    end else if (tc == arf_pkg::TC_WR_QUAD || tc == arf_pkg::TC_RD_QUAD_RSP ||
                 tc == arf_pkg::TC_RD_BLOCK || tc == arf_pkg::TC_WR_BLOCK ||
                 tc == arf_pkg::TC_RD_BLOCK_RSP || tc == arf_pkg::TC_LOCK_REQ ||
                 tc == arf_pkg::TC_LOCK_RSP) begin
      hdr_last = 2'd3;
    end else begin
      hdr_last = 2'd0;
    end
  endfunction
  // Layouts that carry a block payload after the header
  function automatic logic has_payload(input logic [3:0] tc);
    has_payload = tc == arf_pkg::TC_WR_BLOCK || tc == arf_pkg::TC_RD_BLOCK_RSP ||
                  tc == arf_pkg::TC_LOCK_REQ || tc == arf_pkg::TC_LOCK_RSP ||
                  tc == arf_pkg::TC_SELF_ID || tc == arf_pkg::TC_STREAM;
  endfunction
  function automatic logic is_response(input logic [3:0] tc);
    is_response = tc == arf_pkg::TC_WR_RSP || tc == arf_pkg::TC_RD_QUAD_RSP ||
                  tc == arf_pkg::TC_RD_BLOCK_RSP || tc == arf_pkg::TC_LOCK_RSP;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  arf_pkg::arf_state_e state;
  arf_pkg::arf_state_e next_state;
  logic enable;
  logic [15:0] pkt_count;
  logic [3:0] last_transaction_code;
  logic last_error;
  logic [3:0] transaction_code;
  logic [15:0] dest_node_ident;
  logic [5:0] transaction_label;
  logic [1:0] retry_code;
  logic [3:0] priority_field;
  logic [15:0] sender_node_ident;
  logic [15:0] dest_offset_upper;
  logic [31:0] dest_offset_lower;
  logic [3:0] response_code;
  logic [31:0] quad_data;
  logic [15:0] data_length;
  logic [15:0] lock_action_code;
  logic [31:0] stream_hdr;
  logic unsolicited;
  logic data_error;
  logic conf_rsp;
  logic [1:0] hdr_idx;
  logic [15:0] bytes_left;
  logic [1:0] byte_idx;
  logic [31:0] pay_word;
  logic out_valid;
  logic out_rsp;
  logic out_trailer;
  logic out_first;
  logic out_last_pay;

  // ****************************************************************
  // Handshake and quadlet assembly
  // ****************************************************************
  wire accept = pkt_valid_i && pkt_ready_o;
  wire advance = ce_i && (!out_valid || fifo_ready_i);
  wire take_byte = pay_valid_i && pay_ready_o;
  wire out_taken = ce_i && out_valid && fifo_ready_i;
  wire hdr_done = hdr_idx == hdr_last(transaction_code);
  wire pay_needed = has_payload(transaction_code) && data_length != 16'h0000;
  wire word_done = byte_idx == 2'd3 || bytes_left == 16'h0001;
  wire rsp_layout = is_response(transaction_code);
  wire lock_layout = transaction_code == arf_pkg::TC_LOCK_REQ || transaction_code == arf_pkg::TC_LOCK_RSP;
  // First byte lands at bit 31, each later one a byte lower
  wire [4:0] byte_shift = {~byte_idx, 3'b000};
  wire [31:0] next_pay_word = pay_word | ({24'h000000, pay_byte_i} << byte_shift);
  assign pkt_ready_o = ce_i && enable && state == arf_pkg::ARF_IDLE && !out_valid;
  assign pay_ready_o = ce_i && state == arf_pkg::ARF_PAY_COLLECT;
  assign req_wr_o = out_valid && !out_rsp;
  assign rsp_wr_o = out_valid && out_rsp;
  // Header quadlets; stream and self-ID take a single leading quadlet
  wire [31:0] hdr_q0 = {dest_node_ident, transaction_label, retry_code, transaction_code,
                        priority_field};
  wire [31:0] hdr_stream = stream_hdr;
  wire [31:0] hdr_q1 = rsp_layout ? {sender_node_ident, response_code, 12'h000}
                                  : {sender_node_ident, dest_offset_upper};
  wire [31:0] hdr_q2 = rsp_layout ? 32'h00000000 : dest_offset_lower;
  // Lock action is zero except on lock layouts
  wire [31:0] hdr_len = {data_length, lock_layout ? lock_action_code : 16'h0000};
  wire quad_layout = transaction_code == arf_pkg::TC_WR_QUAD || transaction_code == arf_pkg::TC_RD_QUAD_RSP;
  wire [31:0] hdr_q3 = quad_layout ? quad_data : hdr_len;
  wire [31:0] hdr_first = transaction_code == arf_pkg::TC_STREAM ? hdr_stream : hdr_q0;
  wire [31:0] hdr_word = hdr_idx == 2'd0 ? hdr_first :
                         hdr_idx == 2'd1 ? hdr_q1 :
                         hdr_idx == 2'd2 ? hdr_q2 : hdr_q3;
  // Acknowledge choice; data error only for packets that carry data
  wire [3:0] ack_code = (data_error && has_payload(transaction_code)) ? arf_pkg::ACK_DATA_ERROR :
                        (transaction_code == arf_pkg::TC_RD_QUAD || transaction_code == arf_pkg::TC_RD_BLOCK ||
                         transaction_code == arf_pkg::TC_LOCK_REQ) ? arf_pkg::ACK_PENDING :
                        arf_pkg::ACK_COMPLETE;
  wire [3:0] stream_status = data_error ? arf_pkg::STREAM_BAD : arf_pkg::STREAM_OK;
  wire [3:0] status_code = transaction_code == arf_pkg::TC_STREAM ? stream_status : ack_code;
  wire unsol_bit = rsp_layout && unsolicited;
  wire [31:0] trailer_word = {15'h0000, unsol_bit, 12'h000, status_code};
  // Requests and self-ID go to the request FIFO; responses and streams to the other
  wire route_rsp = transaction_code == arf_pkg::TC_CONFIRM ? conf_rsp :
                   (rsp_layout || transaction_code == arf_pkg::TC_STREAM);

  // ****************************************************************
  // Formatter sequence
  // ****************************************************************
  // Next state: a quadlet is issued only on advance, so one per cycle
  always_comb begin
    next_state = state;
    case (state)
      arf_pkg::ARF_IDLE: begin
        if (accept) begin
          next_state = arf_pkg::ARF_HDR;
        end
      end
      arf_pkg::ARF_HDR: begin
        if (advance && hdr_done) begin
          next_state = pay_needed ? arf_pkg::ARF_PAY_COLLECT : arf_pkg::ARF_TRAILER;
        end
      end
      arf_pkg::ARF_PAY_COLLECT: begin
        if (take_byte && word_done) begin
          next_state = arf_pkg::ARF_PAY_WRITE;
        end
      end
      arf_pkg::ARF_PAY_WRITE: begin
        if (advance) begin
          next_state = bytes_left == 16'h0000 ? arf_pkg::ARF_TRAILER
                                              : arf_pkg::ARF_PAY_COLLECT;
        end
      end
      arf_pkg::ARF_TRAILER: begin
        if (advance) begin
          next_state = arf_pkg::ARF_IDLE;
        end
      end
      default: next_state = arf_pkg::ARF_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= arf_pkg::ARF_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end
  // Header fields are held for the whole packet
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transaction_code <= 4'h0;
      dest_node_ident <= 16'h0000;
      transaction_label <= 6'h00;
      retry_code <= 2'h0;
      priority_field <= 4'h0;
      sender_node_ident <= 16'h0000;
      dest_offset_upper <= 16'h0000;
      dest_offset_lower <= 32'h00000000;
      response_code <= 4'h0;
      quad_data <= 32'h00000000;
      data_length <= 16'h0000;
      lock_action_code <= 16'h0000;
      stream_hdr <= 32'h00000000;
      unsolicited <= 1'b0;
      conf_rsp <= 1'b0;
    end else if (accept) begin
      transaction_code <= pkt_transaction_code_i;
      dest_node_ident <= pkt_dest_node_ident_i;
      transaction_label <= pkt_transaction_label_i;
      retry_code <= pkt_retry_code_i;
      priority_field <= pkt_priority_i;
      sender_node_ident <= pkt_sender_node_ident_i;
      dest_offset_upper <= pkt_dest_offset_upper_i;
      dest_offset_lower <= pkt_dest_offset_lower_i;
      response_code <= pkt_response_code_i;
      quad_data <= pkt_quad_data_i;
      data_length <= pkt_data_length_i;
      lock_action_code <= pkt_lock_action_code_i;
      stream_hdr <= pkt_stream_hdr_i;
      unsolicited <= pkt_unsolicited_i;
      conf_rsp <= pkt_conf_rsp_i;
    end
  end
  // Header index, payload byte count and packing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hdr_idx <= 2'd0;
      bytes_left <= 16'h0000;
      byte_idx <= 2'd0;
      pay_word <= 32'h00000000;
      data_error <= 1'b0;
    end else if (accept) begin
      hdr_idx <= 2'd0;
      bytes_left <= pkt_data_length_i;
      byte_idx <= 2'd0;
      pay_word <= 32'h00000000;
      data_error <= pkt_data_error_i;
    end else if (ce_i) begin
      if (state == arf_pkg::ARF_HDR && advance) begin
        hdr_idx <= hdr_idx + 2'd1;
      end
      if (take_byte) begin
        pay_word <= next_pay_word;
        byte_idx <= byte_idx + 2'd1;
        bytes_left <= bytes_left - 16'h0001;
        data_error <= data_error | pay_error_i;
      end
      // Cleared word leaves zero bytes behind a short last quadlet
      if (state == arf_pkg::ARF_PAY_WRITE && advance) begin
        pay_word <= 32'h00000000;
        byte_idx <= 2'd0;
      end
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  // Registered quadlet; held while the FIFO is not ready
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid <= 1'b0;
      out_rsp <= 1'b0;
      out_trailer <= 1'b0;
      out_first <= 1'b0;
      out_last_pay <= 1'b0;
      fifo_data_o <= 32'h00000000;
    end else if (advance) begin
      out_valid <= 1'b0;
      out_trailer <= 1'b0;
      out_first <= 1'b0;
      out_last_pay <= 1'b0;
      if (state == arf_pkg::ARF_HDR) begin
        out_valid <= 1'b1;
        out_rsp <= route_rsp;
        out_first <= hdr_idx == 2'd0;
        fifo_data_o <= hdr_word;
      end else if (state == arf_pkg::ARF_PAY_WRITE) begin
        out_valid <= 1'b1;
        out_last_pay <= bytes_left == 16'h0000;
        fifo_data_o <= pay_word;
      end else if (state == arf_pkg::ARF_TRAILER) begin
        out_valid <= 1'b1;
        out_trailer <= 1'b1;
        fifo_data_o <= trailer_word;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Control write, packet statistics; disabling only stops new packets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable <= arf_pkg::CTRL_ENABLE_RST;
      pkt_count <= 16'h0000;
      last_transaction_code <= 4'h0;
      last_error <= 1'b0;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == arf_pkg::REG_CTRL) begin
        enable <= reg_wdata_i[0];
      end
      if (out_taken && out_trailer) begin
        pkt_count <= pkt_count + 16'h0001;
        last_transaction_code <= transaction_code;
        last_error <= data_error;
      end
    end
  end
  // Read decode; unmapped addresses read as zero
  wire busy = state != arf_pkg::ARF_IDLE || out_valid;
  wire [31:0] rd_value = reg_addr_i == arf_pkg::REG_CTRL ? {31'h00000000, enable} :
                         reg_addr_i == arf_pkg::REG_STATUS ?
                           {23'h000000, last_error, last_transaction_code, 3'h0, busy} :
                         reg_addr_i == arf_pkg::REG_COUNT ? {16'h0000, pkt_count} :
                         32'h00000000;
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_value : 32'h00000000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_one_fifo_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(req_wr_o && rsp_wr_o)) else $error("Both FIFO writes active");
  a_stream_to_rsp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && transaction_code == arf_pkg::TC_STREAM) |-> rsp_wr_o)
    else $error("Stream quadlet not routed to response FIFO");
  a_self_id_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && out_first && transaction_code == arf_pkg::TC_SELF_ID) |->
      (req_wr_o && fifo_data_o[7:4] == arf_pkg::TC_SELF_ID))
    else $error("Self-ID header wrong");
  a_header_fields: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && out_first && transaction_code != arf_pkg::TC_STREAM) |->
      (fifo_data_o[7:4] == transaction_code && fifo_data_o[15:10] == transaction_label))
    else $error("First header quadlet lost code or label");
  a_trailer_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_taken && out_trailer) |=> (state == arf_pkg::ARF_IDLE && !out_valid))
    else $error("Packet did not end after trailer");
  a_zero_len_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == arf_pkg::ARF_HDR && advance && hdr_done && data_length == 16'h0000) |=>
      (state == arf_pkg::ARF_TRAILER))
    else $error("Zero-length block wrote payload");
  a_pad_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && out_last_pay && data_length[1:0] == 2'd1) |->
      fifo_data_o[23:0] == 24'h000000)
    else $error("Final quadlet not zero padded");
  a_stream_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && out_trailer && transaction_code == arf_pkg::TC_STREAM) |->
      fifo_data_o[3:0] == (data_error ? arf_pkg::STREAM_BAD : arf_pkg::STREAM_OK))
    else $error("Stream status code wrong");
  a_unsol_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && out_trailer) |->
      fifo_data_o[arf_pkg::TRL_UNSOL_BIT] == (rsp_layout && unsolicited))
    else $error("Unsolicited flag wrong");
  a_hold_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid && !fifo_ready_i && ce_i) |=> (out_valid && $stable(fifo_data_o)))
    else $error("Quadlet changed while stalled");

endmodule

// >>> dv/arf_fifo_sink.sv
`timescale 1ns/100ps
module arf_fifo_sink (
  // Clock and pacing
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic slow_i,
  // Formatter write side
  input wire logic req_wr_i,
  input wire logic rsp_wr_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  // ****************************************************************
  // Receive FIFO stand-in
  // ****************************************************************
  logic [31:0] got [$];
  logic route [$];
  logic [1:0] tick = 2'h0;
  // Slow mode takes one quadlet in four cycles, so a waiting quadlet must stand
  always @(posedge clk_i) begin
    tick <= tick + 2'h1;
    if ((req_wr_i || rsp_wr_i) && ready_o && ce_i) begin
      got.push_back(data_i);
      route.push_back(rsp_wr_i);
    end
  end
  assign ready_o = !slow_i || tick == 2'h3;
endmodule

// >>> dv/arf_rx_formatter_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module arf_rx_formatter_tb_top;
  // ****************************************************************
  // Rows, expectations and stimulus
  // ****************************************************************
  typedef struct packed {
    logic [3:0] tc;
    logic [15:0] len;
    logic err;
    logic slow;
    logic [3:0] st;
    logic [3:0] nq;
  } arf_row_s;
  // Code, payload bytes, error, slow consumer, trailer status, quadlets stored
  arf_row_s rows [13] = '{
    '{4'h0, 16'h0, 1'b0, 1'b0, 4'h1, 4'h5}, '{4'h1, 16'h5, 1'b1, 1'b0, 4'hd, 4'h7},
    '{4'h2, 16'h0, 1'b0, 1'b0, 4'h1, 4'h4}, '{4'h4, 16'h0, 1'b1, 1'b0, 4'h2, 4'h4},
    '{4'h5, 16'h8, 1'b0, 1'b0, 4'h2, 4'h5}, '{4'h6, 16'h0, 1'b0, 1'b1, 4'h1, 4'h5},
    '{4'h7, 16'h0, 1'b0, 1'b0, 4'h1, 4'h5}, '{4'h9, 16'h8, 1'b0, 1'b1, 4'h2, 4'h7},
    '{4'hb, 16'h4, 1'b0, 1'b0, 4'h1, 4'h6}, '{4'he, 16'h3, 1'b0, 1'b0, 4'h1, 4'h3},
    '{4'ha, 16'h6, 1'b1, 1'b1, 4'hd, 4'h4}, '{4'ha, 16'h0, 1'b0, 1'b0, 4'h1, 4'h2},
    '{4'h8, 16'h0, 1'b0, 1'b0, 4'h1, 4'h2}};
  arf_row_s cur = '0;
  int kk = 0;
  int mismatches = 0;
  int n_compared = 0;
  int exp_h;
  logic exp_rsp;
  logic [31:0] exp_q [$];
  logic [31:0] got [$];
  logic rt [$];
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic pkt_valid_i = 1'b0;
  logic pay_valid_i = 1'b0;
  logic ce = 1'b1;
  logic hung = 1'b0;
  logic [7:0] nb = 8'h00;
  logic [31:0] reg_rdata_o;
  logic [31:0] fifo_data_o;
  logic pkt_ready_o, pay_ready_o, req_wr_o, rsp_wr_o, fifo_ready_i;
  // Fields move with the row number so a swapped field cannot match by luck
  wire [15:0] dst = 16'hffc0 + 16'(kk);
  wire [5:0] lbl = 6'(kk * 5);
  wire [1:0] rty = 2'(kk);
  wire [15:0] src = 16'h1200 + 16'(kk);
  wire [15:0] upr = 16'hab00 + 16'(kk);
  wire [31:0] lwr = 32'h76543200 + 32'(kk);
  wire [3:0] rc = 4'(kk);
  wire [31:0] qd = 32'hdead0000 + 32'(kk);
  wire [15:0] lk = 16'(kk + 1);
  wire [31:0] sh = 32'h00060a50 + 32'(kk);
  wire uns = kk[0];
  wire cnf = kk[2];
  wire [3:0] pri = 4'(kk + 3);
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // Byte n of a block is 10h+n; slow rows leave a gap after each taken byte
  always @(posedge clk_i) begin
    if (pkt_valid_i && pkt_ready_o) nb <= 8'h00;
    else if (pay_valid_i && pay_ready_o) nb <= nb + 8'h01;
    pay_valid_i <= !(cur.slow && pay_valid_i && pay_ready_o);
  end
  arf_rx_formatter u_arf_rx_formatter (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i),
    .pkt_ready_o(pkt_ready_o), .pkt_transaction_code_i(cur.tc), .pkt_dest_node_ident_i(dst),
    .pkt_transaction_label_i(lbl), .pkt_retry_code_i(rty), .pkt_priority_i(pri),
    .pkt_sender_node_ident_i(src), .pkt_dest_offset_upper_i(upr),
    .pkt_dest_offset_lower_i(lwr), .pkt_response_code_i(rc), .pkt_quad_data_i(qd),
    .pkt_data_length_i(cur.len), .pkt_lock_action_code_i(lk), .pkt_stream_hdr_i(sh),
    .pkt_unsolicited_i(uns), .pkt_data_error_i(cur.err), .pkt_conf_rsp_i(cnf),
    .pay_valid_i(pay_valid_i), .pay_ready_o(pay_ready_o), .pay_byte_i(8'h10 + nb),
    .pay_error_i(cur.err), .req_wr_o(req_wr_o), .rsp_wr_o(rsp_wr_o),
    .fifo_data_o(fifo_data_o), .fifo_ready_i(fifo_ready_i));
  arf_fifo_sink u_arf_fifo_sink (.clk_i(clk_i), .ce_i(ce), .slow_i(cur.slow),
    .req_wr_i(req_wr_o), .rsp_wr_i(rsp_wr_o), .data_i(fifo_data_o), .ready_o(fifo_ready_i));
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(n, e, reg_rdata_o)
  endtask
  function automatic void build();
    logic rsp;
    logic pay;
    logic [3:0] st;
    logic [31:0] w;
    rsp = cur.tc inside {4'h2, 4'h6, 4'h7, 4'hb};
    pay = cur.tc inside {4'h1, 4'h7, 4'h9, 4'hb, 4'he, 4'ha};
    exp_rsp = rsp || cur.tc == 4'ha || (cur.tc == 4'h8 && cnf);
    exp_q.delete();
    exp_q.push_back(cur.tc == 4'ha ? sh : {dst, lbl, rty, cur.tc, pri});
    if (!(cur.tc inside {4'h8, 4'ha, 4'he})) begin
      exp_q.push_back({src, rsp ? {rc, 12'h000} : upr});
      exp_q.push_back(rsp ? 32'h0 : lwr);
    end
    if (cur.tc inside {4'h0, 4'h6}) exp_q.push_back(qd);
    if (cur.tc inside {4'h1, 4'h5, 4'h7, 4'h9, 4'hb})
      exp_q.push_back({cur.len, cur.tc inside {4'h9, 4'hb} ? lk : 16'h0});
    exp_h = exp_q.size();
    w = 32'h0;
    for (int i = 0; pay && i < cur.len; i++) begin
      w[31 - 8 * (i % 4) -: 8] = 8'h10 + 8'(i);
      if (i % 4 == 3 || i == cur.len - 1) begin
        exp_q.push_back(w);
        w = 32'h0;
      end
    end
    st = cur.st;
    exp_q.push_back({15'h0, rsp & uns, 12'h000, st});
  endfunction
  task automatic send(input int k);
    int t;
    @(posedge clk_i);
    kk <= k;
    cur <= rows[k];
    pkt_valid_i <= 1'b1;
    u_arf_fifo_sink.got.delete();
    u_arf_fifo_sink.route.delete();
    @(negedge clk_i);
    build();
    for (t = 0; t < 20 && pkt_ready_o !== 1'b1; t++) @(negedge clk_i);
    // A refused header spends the whole budget at once
    if (t == 20) t = 300;
    @(posedge clk_i);
    pkt_valid_i <= 1'b0;
    for (t = t; t < 300 && u_arf_fifo_sink.got.size() < exp_q.size(); t++) @(posedge clk_i);
    if (t >= 300) begin
      mismatches++;
      hung = 1'b1;
      $display("test %0d timed out", k);
      return;
    end
    repeat (4) @(posedge clk_i);
    got = u_arf_fifo_sink.got;
    rt = u_arf_fifo_sink.route;
    `CHK("quadlets", int'(cur.nq), got.size())
    foreach (exp_q[i]) begin
      `CHK("route", exp_rsp, rt[i])
      if (i < exp_h)
        `CHK("header", exp_q[i], got[i])
      else if (i < exp_q.size() - 1)
        `CHK("payload", exp_q[i], got[i])
      else
        `CHK("trailer", exp_q[i], got[i])
    end
    $display("test %0d code %h done", k, rows[k].tc);
  endtask
  // Reset, enable, the row loop, then counters and an unmapped address
  initial begin
    repeat (16) @(posedge clk_i);
    `CHK("reset ready", 1'b0, pkt_ready_o)
    rst_n_i <= 1'b1;
    rreg(8'h00, 32'h0, "ctrl");
    `CHK("disabled ready", 1'b0, pkt_ready_o)
    wreg(8'h00, 32'h1);
    for (int k = 0; k < 13 && !hung; k++) send(k);
    wreg(8'h08, 32'h0);
    rreg(8'h08, 32'h0000000d, "count");
    rreg(8'h04, 32'h00000080, "status");
    rreg(8'h3c, 32'h0, "unmapped");
    $display("register test done");
    // Clock enable low must swallow a write and keep the header port shut
    @(posedge clk_i);
    ce <= 1'b0;
    wreg(8'h00, 32'h0);
    `CHK("frozen ready", 1'b0, pkt_ready_o)
    ce <= 1'b1;
    rreg(8'h00, 32'h1, "ctrl held");
    $display("clock enable test done");
    // Reset in mid-run clears the enable and the packet count
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rreg(8'h08, 32'h0, "count after reset");
    rreg(8'h00, 32'h0, "ctrl after reset");
    $display("reset test done");
    give_verdict();
  end
endmodule
